//--- common/ivp_pkg.sv
// package: constants for the interrupt vector placement block
package ivp_pkg;
  localparam int ADDR_W = 16;
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_FUSES = 4'h8;
  localparam logic [3:0] OFF_VECTOR = 4'hC;
  localparam int BIT_CHANGE_EN = 0;
  localparam int BIT_TABLE_SEL = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h91;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] TABLE_FIRST = 16'h0002;
  localparam logic [15:0] SLOT_WORDS = 16'h0002;
  localparam int CHANGE_WINDOW = 4;
  localparam logic [2:0] CHANGE_CYCLES = 3'(CHANGE_WINDOW);
  localparam int VEC_COUNT = 29;
  localparam logic [4:0] VEC_ANALOG_CMP = 5'h1B;
  localparam logic [4:0] VEC_NVDATA_READY = 5'h1C;
  localparam logic [4:0] VEC_PROG_STORE_READY = 5'h1D;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hdl/ivp_vector_place.sv
// interrupt vector placement with timed vector table select change
`timescale 1ns/1ps
module ivp_vector_place
  import ivp_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BOOT_START_0 = 16'h1C00,
  parameter logic [ADDR_W-1:0] BOOT_START_1 = 16'h1E00,
  parameter logic [ADDR_W-1:0] BOOT_START_2 = 16'h1F00,
  parameter logic [ADDR_W-1:0] BOOT_START_3 = 16'h1F80
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // fuses and lock bits, static levels
  input wire logic boot_reset_fuse_in,
  input wire logic [1:0] boot_size_fuse_in,
  input wire logic app_interrupt_lock_bit_in,
  input wire logic boot_interrupt_lock_bit_in,
  // core side
  input wire logic [ADDR_W-1:0] core_pc_in,
  input wire logic core_instr_done_in,
  input wire logic [4:0] core_vector_num_in,
  output logic [ADDR_W-1:0] reset_address_out,
  output logic [ADDR_W-1:0] vector_address_out,
  output logic irq_block_out
);

  typedef struct packed {
    logic [7:0] control;
    logic [2:0] change_count;
    logic post_select;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ivp_state_s;

  ivp_state_s cur;
  ivp_state_s next_cur;

  logic [ADDR_W-1:0] boot_start;
  logic [ADDR_W-1:0] table_base;
  logic table_sel;
  logic change_en;
  logic in_boot;
  logic seq_mask;
  logic lock_mask;
  logic wr_fire;
  logic [7:0] wr_byte;

  assign table_sel = cur.control[BIT_TABLE_SEL];
  assign change_en = cur.control[BIT_CHANGE_EN];

  // boot start picked by fuse
  always_comb begin
    case (boot_size_fuse_in)
      2'h0: boot_start = BOOT_START_0;
      2'h1: boot_start = BOOT_START_1;
      2'h2: boot_start = BOOT_START_2;
      default: boot_start = BOOT_START_3;
    endcase
  end

  assign reset_address_out = boot_reset_fuse_in ? RESET_VECTOR : boot_start;
  assign table_base = table_sel ? boot_start : RESET_VECTOR;
  // fixed two-word slots; vector 1 lands on base, 27..29 follow at 0x34..0x38
  assign vector_address_out = table_base + 16'(SLOT_WORDS * 16'(core_vector_num_in - 5'h01));

  assign in_boot = (core_pc_in >= boot_start);
  assign lock_mask = (table_sel && app_interrupt_lock_bit_in && !in_boot)
    || (!table_sel && boot_interrupt_lock_bit_in && in_boot);
  // only a block line to the core: the global enable flag stays untouched
  assign seq_mask = change_en || cur.post_select;
  assign irq_block_out = seq_mask || lock_mask;

  assign s_axi_awready_out = !cur.aw_held;
  assign s_axi_wready_out = !cur.w_held;
  assign s_axi_arready_out = !cur.rvalid;
  assign s_axi_bvalid_out = cur.bvalid;
  assign s_axi_bresp_out = cur.bresp;
  assign s_axi_rvalid_out = cur.rvalid;
  assign s_axi_rdata_out = cur.rdata;
  assign s_axi_rresp_out = cur.rresp;

  assign wr_fire = cur.aw_held && cur.w_held && !cur.bvalid;
  assign wr_byte = cur.w_data[7:0];

  always_comb begin
    next_cur = cur;
    if (s_axi_awvalid_in && !cur.aw_held) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !cur.w_held) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata_in;
      next_cur.w_strb = s_axi_wstrb_in;
    end
    if (cur.bvalid && s_axi_bready_in) begin
      next_cur.bvalid = 1'b0;
    end
    // change window timer
    if (change_en) begin
      if (cur.change_count <= 3'h1) begin
        next_cur.control[BIT_CHANGE_EN] = 1'b0;
        next_cur.change_count = 3'h0;
      end else begin
        next_cur.change_count = cur.change_count - 3'h1;
      end
    end
    // mask holds until the core retires the instruction after the select write
    if (cur.post_select && core_instr_done_in) begin
      next_cur.post_select = 1'b0;
    end
    if (wr_fire) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = RESP_OKAY;
      if (cur.aw_addr == OFF_CONTROL) begin
        if (cur.w_strb[0]) begin
          // keep other bits; select only moves inside the window
          next_cur.control = (cur.control & ~CONTROL_WMASK) | (wr_byte & CONTROL_WMASK);
          next_cur.control[BIT_TABLE_SEL] = table_sel;
          if (change_en && !wr_byte[BIT_CHANGE_EN]) begin
            next_cur.control[BIT_TABLE_SEL] = wr_byte[BIT_TABLE_SEL];
            next_cur.control[BIT_CHANGE_EN] = 1'b0;
            next_cur.change_count = 3'h0;
            next_cur.post_select = 1'b1;
          end else if (wr_byte[BIT_CHANGE_EN]) begin
            next_cur.control[BIT_CHANGE_EN] = 1'b1;
            next_cur.change_count = CHANGE_CYCLES;
          end else begin
            next_cur.control[BIT_CHANGE_EN] = change_en;
          end
        end
      end else if (cur.aw_addr == OFF_STATUS || cur.aw_addr == OFF_FUSES
                   || cur.aw_addr == OFF_VECTOR) begin
        next_cur.bresp = RESP_OKAY;
      end else begin
        next_cur.bresp = RESP_SLVERR;
      end
    end
    if (cur.rvalid && s_axi_rready_in) begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !cur.rvalid) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      if (s_axi_araddr_in == OFF_CONTROL) begin
        next_cur.rdata = {24'h00_0000, cur.control};
      end else if (s_axi_araddr_in == OFF_STATUS) begin
        next_cur.rdata = {28'h000_0000, lock_mask, seq_mask, cur.change_count > 3'h0,
                          cur.post_select};
      end else if (s_axi_araddr_in == OFF_FUSES) begin
        next_cur.rdata = {boot_start, 11'h000, boot_interrupt_lock_bit_in,
                          app_interrupt_lock_bit_in, boot_size_fuse_in, boot_reset_fuse_in};
      end else if (s_axi_araddr_in == OFF_VECTOR) begin
        next_cur.rdata = {table_base, reset_address_out};
      end else begin
        next_cur.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur <= '0;
      cur.control <= CONTROL_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // a select write attempted outside the window leaves the bit alone
  sequence ctl_write_no_window_s;
    wr_fire && cur.aw_addr == OFF_CONTROL && cur.w_strb[0] && !change_en;
  endsequence

  sequence change_armed_s;
    !change_en ##1 change_en;
  endsequence

  // a select write inside the window; the value written decides where the table lands
  sequence select_write_s;
    wr_fire && cur.aw_addr == OFF_CONTROL && cur.w_strb[0] && change_en
      && !wr_byte[BIT_CHANGE_EN];
  endsequence

  select_guarded_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_write_no_window_s |=> $stable(table_sel))
    else $error("table select changed outside change window");

  window_expires_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    change_armed_s |-> ##[0:3] !change_en ##0 1'b1 or ##4 !change_en)
    else $error("change enable outlived four cycles");

  window_length_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    change_armed_s ##0 !wr_fire ##1 !wr_fire ##1 !wr_fire |=> change_en)
    else $error("change enable dropped early without select write");

  mask_during_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    change_en |-> irq_block_out)
    else $error("interrupts not masked in change window");

  mask_post_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cur.post_select && !core_instr_done_in |=> irq_block_out)
    else $error("mask dropped before next instruction");

  reset_addr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    boot_reset_fuse_in |-> reset_address_out == RESET_VECTOR)
    else $error("reset address wrong with fuse unprogrammed");

  base_table_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == 5'h02 |->
      vector_address_out == (table_sel ? boot_start + TABLE_FIRST : TABLE_FIRST))
    else $error("vector table start wrong");

  last_vector_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == VEC_PROG_STORE_READY && !table_sel |->
      vector_address_out == 16'h0038)
    else $error("program store ready vector misplaced");

  app_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    table_sel && app_interrupt_lock_bit_in && core_pc_in < boot_start |-> irq_block_out)
    else $error("application code not blocked");

  boot_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !table_sel && boot_interrupt_lock_bit_in && core_pc_in >= boot_start |-> irq_block_out)
    else $error("boot code not blocked");

  write_resp_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_fire |=> s_axi_bvalid_out)
    else $error("write response missing");

  select_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    select_write_s ##0 wr_byte[BIT_TABLE_SEL] |=> table_sel)
    else $error("table select not set by window write");

  select_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    select_write_s ##0 !wr_byte[BIT_TABLE_SEL] |=> !table_sel)
    else $error("table select not cleared by window write");

  window_cut_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    select_write_s |=> !change_en && cur.post_select)
    else $error("change enable survived select write");

  window_reload_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_fire && cur.aw_addr == OFF_CONTROL && cur.w_strb[0] && wr_byte[BIT_CHANGE_EN] |=>
      change_en && cur.change_count == CHANGE_CYCLES)
    else $error("change window not opened");

  mask_release_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !change_en && !cur.post_select && !app_interrupt_lock_bit_in
      && !boot_interrupt_lock_bit_in |-> !irq_block_out)
    else $error("interrupts masked with no cause");

  // placement checks compare against fixed table slots, not against the adder
  reset_boot_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !boot_reset_fuse_in |-> reset_address_out == boot_start)
    else $error("reset address wrong with fuse programmed");

  reset_slot_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == 5'h01 && !table_sel |-> vector_address_out == RESET_VECTOR)
    else $error("reset slot not at address zero");

  boot_base_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == 5'h01 && table_sel |-> vector_address_out == boot_start)
    else $error("relocated table not at boot start");

  comparator_vec_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == VEC_ANALOG_CMP && !table_sel |-> vector_address_out == 16'h0034)
    else $error("comparator vector misplaced");

  nvdata_vec_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == VEC_NVDATA_READY && !table_sel |-> vector_address_out == 16'h0036)
    else $error("nvdata ready vector misplaced");

  // neighbouring vector numbers must land exactly one slot apart
  slot_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    core_vector_num_in == $past(core_vector_num_in) + 5'h01 && $stable(table_sel)
      && $stable(boot_size_fuse_in) |->
      vector_address_out == $past(vector_address_out) + SLOT_WORDS)
    else $error("vector slots not two words apart");

  fuse_readback_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == OFF_FUSES |=>
      s_axi_rdata_out[31:16] == $past(boot_start))
    else $error("boot start readback wrong");

  ctl_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == OFF_CONTROL |=>
      s_axi_rdata_out[7:0] == $past(cur.control))
    else $error("control readback wrong");

  read_resp_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response missing");

  read_slverr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 4'h2 |=>
      s_axi_rresp_out == RESP_SLVERR)
    else $error("undecoded read not refused");

endmodule

//--- verification/ivp_core_model.sv
// core-side model: fetch address, dispatched vector number and retire pulses
`timescale 1ns/1ps
module ivp_core_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // bench requests
  input wire logic step_in,
  input wire logic [15:0] pc_in,
  input wire logic [4:0] vec_in,
  // core outputs
  output logic [15:0] core_pc_out,
  output logic core_instr_done_out,
  output logic [4:0] core_vector_num_out
);
  // registered like a real fetch stage, so the block never sees a same-edge change
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_pc_out <= 16'h0000;
      core_instr_done_out <= 1'b0;
      core_vector_num_out <= 5'h01;
    end else begin
      core_pc_out <= pc_in;
      core_instr_done_out <= step_in;
      core_vector_num_out <= vec_in;
    end
  end
endmodule

//--- verification/tb_interrupt_vector_placement.sv
// bench: register access, vector placement and interrupt masking
`timescale 1ns/1ps
module tb_interrupt_vector_placement;
  import ivp_pkg::*;
  logic clk_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready, rst_fuse;
  logic app_lock, boot_lock, step, done_p, irq_block, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] size, rresp, bresp;
  logic [15:0] pc, core_pc, r_addr, v_addr;
  logic [4:0] vec, core_vec;
  logic [16:0] seed;
  logic [33:0] exp_q[$];
  logic [33:0] exp_now;
  int num_errors, samples_checked, i;

  ivp_vector_place ivp_vector_place_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .boot_reset_fuse_in(rst_fuse),
    .boot_size_fuse_in(size), .app_interrupt_lock_bit_in(app_lock),
    .boot_interrupt_lock_bit_in(boot_lock), .core_pc_in(core_pc),
    .core_instr_done_in(done_p), .core_vector_num_in(core_vec),
    .reset_address_out(r_addr), .vector_address_out(v_addr), .irq_block_out(irq_block));
  ivp_core_model ivp_core_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .step_in(step),
    .pc_in(pc), .vec_in(vec), .core_pc_out(core_pc), .core_instr_done_out(done_p),
    .core_vector_num_out(core_vec));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // the monitor pairs each bus answer with the oldest expectation
  always @(negedge clk_in) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      exp_now = exp_q.pop_front();
      if (rvalid) check("read data", rdata, exp_now[31:0]);
      check("response", 32'(rvalid ? rresp : bresp), 32'(exp_now[33:32]));
    end
  end

  // keep leaves bready up so a follow-up write can start on the same edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp,
                    input bit keep = 1'b0);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    exp_q.push_back({resp, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b_ok; n++) begin
      @(negedge clk_in);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      @(posedge clk_in);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    check("write wait", 32'(b_ok), 32'h1);
    if (!b_ok) conclude();
    if (!keep) bready <= 1'b0;
    if (!keep) @(posedge clk_in);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    exp_q.push_back({resp, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !r_ok; n++) begin
      @(negedge clk_in);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      @(posedge clk_in);
      if (ar_ok) arvalid <= 1'b0;
    end
    check("read wait", 32'(r_ok), 32'h1);
    if (!r_ok) conclude();
    rready <= 1'b0;
    @(posedge clk_in);
  endtask

  function automatic logic [15:0] boot_start(input logic [1:0] s);
    return s[1] ? (s[0] ? 16'h1F80 : 16'h1F00) : (s[0] ? 16'h1E00 : 16'h1C00);
  endfunction

  function automatic logic [4:0] rnd_vec();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return 5'(seed % 17'h1D) + 5'h01;
  endfunction

  // two edges let the core model's registered outputs reach the block
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check("irq_block", 32'(irq_block), 32'(exp));
    @(posedge clk_in);
  endtask

  task automatic vchk(input logic [4:0] n, input logic [15:0] base);
    logic [15:0] e;
    e = base + SLOT_WORDS * 16'(n - 5'h01);
    vec <= n;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check("vector", 32'(v_addr), 32'(e));
    check("irq_block", 32'(irq_block), 32'h0);
    @(posedge clk_in);
  endtask

  task automatic sel_change(input logic v);
    wr(OFF_CONTROL, 32'h1, RESP_OKAY, 1'b1);
    wr(OFF_CONTROL, {30'h0, v, 1'b0}, RESP_OKAY);
    chk_irq(1'b1);
    rd(OFF_CONTROL, {30'h0, v, 1'b0}, RESP_OKAY);
    rd(OFF_STATUS, 32'h5, RESP_OKAY);
    step <= 1'b1;
    @(posedge clk_in);
    step <= 1'b0;
    chk_irq(1'b0);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, step, app_lock, boot_lock} = 8'h00;
    {awaddr, araddr, wdata, size, pc} = 58'h0;
    {sys_rst_in, rst_fuse, vec, seed} = {2'h3, 5'h01, 17'h17E83};
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(OFF_CONTROL, 32'h0, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_SLVERR);
    wr(4'h6, 32'h1, RESP_SLVERR);
    wr(OFF_STATUS, 32'hFF, RESP_OKAY);
    $display("done: register access");
    for (i = 0; i < 8; i++) begin
      rst_fuse <= i[2];
      size <= i[1:0];
      chk_irq(1'b0);
      check("reset", 32'(r_addr), 32'(i[2] ? RESET_VECTOR : boot_start(i[1:0])));
    end
    rd(OFF_FUSES, 32'h1F80_0007, RESP_OKAY);
    rd(OFF_VECTOR, 32'h0000_0000, RESP_OKAY);
    $display("done: reset address");
    for (i = 0; i < 12; i++) vchk(i < 4 ? (i == 0 ? 5'h01 : 5'h1A + 5'(i)) : rnd_vec(), 16'h0);
    $display("done: application vectors");
    wr(OFF_CONTROL, 32'h2, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0, RESP_OKAY);
    // no spare edge after the write: the window closes four edges after it lands
    wr(OFF_CONTROL, 32'h1, RESP_OKAY, 1'b1);
    chk_irq(1'b1);
    bready <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk_irq(1'b0);
    rd(OFF_CONTROL, 32'h0, RESP_OKAY);
    $display("done: change window expiry");
    sel_change(1'b1);
    for (i = 0; i < 6; i++) vchk(i == 0 ? 5'h01 : rnd_vec(), boot_start(2'h3));
    rd(OFF_VECTOR, 32'h1F80_0000, RESP_OKAY);
    $display("done: boot vectors");
    app_lock <= 1'b1;
    pc <= 16'h0100;
    chk_irq(1'b1);
    pc <= boot_start(2'h3);
    chk_irq(1'b0);
    app_lock <= 1'b0;
    sel_change(1'b0);
    boot_lock <= 1'b1;
    chk_irq(1'b1);
    pc <= 16'h0100;
    chk_irq(1'b0);
    $display("done: lock masking");
    conclude();
  end
endmodule
